/* File: hw/daft_cfg.svh */
// Constants of the destination address forwarding table.
// Assumes inclusion by the table store and top design files of this block only.
`ifndef DAFT_CFG_SVH
`define DAFT_CFG_SVH
`define DAFT_FILT_FIRST 8'h50
`define DAFT_FILT_LAST 8'h6F
`define DAFT_MASK_FIRST 8'h70
`define DAFT_MASK_LAST 8'h73
`define DAFT_BIT_PORT2 31
`define DAFT_BIT_PORT1 30
`define DAFT_BIT_HIPRI 19
`define DAFT_BIT_PEER 17
`define DAFT_BIT_HOST 16
`define DAFT_UPR_WMASK 32'hC00BFFFF
`define DAFT_UPR_RESET 32'h00000000
`define DAFT_LWR_RESET 32'h00000000
`define DAFT_MASKU_RESET 16'hFFFF
`define DAFT_MASKL_RESET 32'hFFFFFFFF
`define DAFT_MASK_FULL 48'hFFFFFFFFFFFF
`define DAFT_LAST_IDX 4'hF
`define DAFT_MASKED_ENTRIES 4'h2
`define DAFT_ANS_MIN 2
`define DAFT_ANS_MAX 18
`endif

/* File: hw/daft_pkg.sv */
// Types of the destination address forwarding table.
// Assumes daft_cfg.svh on the include path.
package daft_pkg;
  typedef enum logic [1:0] {
    daft_st_idle = 2'b00,
    daft_st_scan = 2'b01,
    daft_st_done = 2'b11
  } daft_state_t;

  typedef enum logic {
    daft_rx_first = 1'b0,
    daft_rx_second = 1'b1
  } daft_rx_port_t;

  typedef struct packed {
    logic filt;
    logic mask;
    logic lower;
    logic [3:0] idx;
  } daft_dec_t;
endpackage

/* File: hw/daft_table_mem.sv */
// Sixteen-entry table store, one word per entry: rule and upper address over lower address.
// Assumes one clock, synchronous active-low reset; both read ports answer one cycle later.
`timescale 1ns/1ps
`include "daft_cfg.svh"
module daft_table_mem (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [63:0] wr_data,
  // Register read port
  input wire logic [3:0] a_addr,
  output logic [63:0] a_rdata,
  // Scan read port
  input wire logic [3:0] b_addr,
  output logic [63:0] b_rdata
);
  logic [63:0] mem_ff [16];
  logic [63:0] nxt_mem [16];
  logic [63:0] a_rdata_ff;
  logic [63:0] b_rdata_ff;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (wr_en) begin
      nxt_mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        mem_ff[i] <= {`DAFT_UPR_RESET, `DAFT_LWR_RESET};
      end
      a_rdata_ff <= {`DAFT_UPR_RESET, `DAFT_LWR_RESET};
      b_rdata_ff <= {`DAFT_UPR_RESET, `DAFT_LWR_RESET};
    end else begin
      for (int i = 0; i < 16; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      a_rdata_ff <= mem_ff[a_addr];
      b_rdata_ff <= mem_ff[b_addr];
    end
  end

  assign a_rdata = a_rdata_ff;
  assign b_rdata = b_rdata_ff;

  property p_commit_lower(int e);
    @(posedge clock) disable iff (!resetn)
      $past(resetn) && $changed(mem_ff[e]) |-> $past(wr_en) && $past(wr_addr) == 4'(e);
  endproperty
  for (genvar g = 0; g < 16; g++) begin : g_commit
    a_commit_lower: assert property (p_commit_lower(g)) else $error("table word changed without commit");
  end
endmodule

/* File: hw/daft_top.sv */
// Destination address filter and forwarding table with its register port and lookup engine.
// Assumes the serial host engine drives the register port and the switch drives lookups, same clock.
`timescale 1ns/1ps
`include "daft_cfg.svh"
module daft_top (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Lookup request
  input wire logic lookup_req,
  input wire logic [47:0] lookup_da,
  input wire daft_pkg::daft_rx_port_t lookup_port,
  // Lookup answer
  output logic lookup_busy,
  output logic lookup_done,
  output logic lookup_hit,
  output logic forward_port_a,
  output logic forward_to_peer_port,
  output logic lookup_drop,
  output logic host_queue_priority
);
  import daft_pkg::*;

  function automatic daft_dec_t daft_decode(input logic [7:0] a);
    logic [7:0] off;
    daft_dec_t d;
    off = a - `DAFT_FILT_FIRST;
    d = '0;
    if (a >= `DAFT_FILT_FIRST && a <= `DAFT_FILT_LAST) begin
      d.filt = 1'b1;
      d.lower = off[0];
      d.idx = off[4:1];
    end else if (a >= `DAFT_MASK_FIRST && a <= `DAFT_MASK_LAST) begin
      off = a - `DAFT_MASK_FIRST;
      d.mask = 1'b1;
      d.lower = off[0];
      d.idx = {3'h0, off[1]};
    end
    return d;
  endfunction

  // Register side state
  daft_dec_t wr_dec, rd_dec, rd_dec_ff, nxt_rd_dec;
  logic [31:0] stage_upr_ff, nxt_stage_upr;
  logic [15:0] stage_mask_ff, nxt_stage_mask;
  logic [47:0] mask_ff [2];
  logic [47:0] nxt_mask [2];
  logic rd_pend_ff, nxt_rd_pend;
  logic [31:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic mem_we;
  logic [63:0] mem_a_rdata, mem_b_rdata;

  assign wr_dec = daft_decode(reg_addr);
  assign rd_dec = daft_decode(reg_addr);
  assign mem_we = reg_wr_en && wr_dec.filt && wr_dec.lower;

  always_comb begin
    nxt_stage_upr = stage_upr_ff;
    nxt_stage_mask = stage_mask_ff;
    nxt_mask = mask_ff;
    nxt_rd_pend = reg_rd_en;
    nxt_rd_dec = rd_dec;
    nxt_rvalid = rd_pend_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr_en && wr_dec.filt && !wr_dec.lower) begin
      nxt_stage_upr = reg_wdata & `DAFT_UPR_WMASK;
    end
    if (reg_wr_en && wr_dec.mask) begin
      if (!wr_dec.lower) begin
        nxt_stage_mask = reg_wdata[15:0];
      end else begin
        nxt_mask[wr_dec.idx[0]] = {stage_mask_ff, reg_wdata};
      end
    end
    if (rd_pend_ff) begin
      nxt_rdata = 32'h00000000;
      if (rd_dec_ff.filt) begin
        nxt_rdata = rd_dec_ff.lower ? mem_a_rdata[31:0] : mem_a_rdata[63:32];
      end else if (rd_dec_ff.mask) begin
        nxt_rdata = rd_dec_ff.lower ? mask_ff[rd_dec_ff.idx[0]][31:0] :
                    {16'h0000, mask_ff[rd_dec_ff.idx[0]][47:32]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage_upr_ff <= `DAFT_UPR_RESET;
      stage_mask_ff <= `DAFT_MASKU_RESET;
      mask_ff[0] <= {`DAFT_MASKU_RESET, `DAFT_MASKL_RESET};
      mask_ff[1] <= {`DAFT_MASKU_RESET, `DAFT_MASKL_RESET};
      rd_pend_ff <= 1'b0;
      rd_dec_ff <= '0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      stage_upr_ff <= nxt_stage_upr;
      stage_mask_ff <= nxt_stage_mask;
      mask_ff <= nxt_mask;
      rd_pend_ff <= nxt_rd_pend;
      rd_dec_ff <= nxt_rd_dec;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
    end
  end

  // Lookup state
  daft_state_t state_ff, nxt_state;
  logic [4:0] idx_ff, nxt_idx;
  logic chk_ff, nxt_chk;
  logic [3:0] chk_idx_ff, nxt_chk_idx;
  logic [47:0] da_ff, nxt_da;
  daft_rx_port_t port_ff, nxt_port;
  logic done_ff, nxt_done, hit_ff, nxt_hit, busy_ff, nxt_busy, drop_ff, nxt_drop, hipri_ff, nxt_hipri;
  logic [31:0] hit_upr_ff, nxt_hit_upr;
  logic [47:0] hit_addr_ff, nxt_hit_addr, hit_mask_ff, nxt_hit_mask;
  logic [31:0] e_upr;
  logic [47:0] e_addr, e_mask;
  logic e_en, e_match;

  daft_table_mem u_mem (
    .clock(clock),
    .resetn(resetn),
    .wr_en(mem_we),
    .wr_addr(wr_dec.idx),
    .wr_data({stage_upr_ff, reg_wdata}),
    .a_addr(rd_dec.idx),
    .a_rdata(mem_a_rdata),
    .b_addr(idx_ff[3:0]),
    .b_rdata(mem_b_rdata)
  );

  always_comb begin
    e_upr = mem_b_rdata[63:32];
    e_addr = {e_upr[15:0], mem_b_rdata[31:0]};
    e_mask = (chk_idx_ff < `DAFT_MASKED_ENTRIES) ? mask_ff[chk_idx_ff[0]] : `DAFT_MASK_FULL;
    e_en = (port_ff == daft_rx_second) ? e_upr[`DAFT_BIT_PORT2] : e_upr[`DAFT_BIT_PORT1];
    e_match = chk_ff && e_en && (((e_addr ^ da_ff) & e_mask) == 48'h000000000000);
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_chk = 1'b0;
    nxt_chk_idx = idx_ff[3:0];
    nxt_da = da_ff;
    nxt_port = port_ff;
    nxt_done = 1'b0;
    nxt_hit = hit_ff;
    nxt_hit_upr = hit_upr_ff;
    nxt_hit_addr = hit_addr_ff;
    nxt_hit_mask = hit_mask_ff;
    case (state_ff)
      daft_st_idle: begin
        if (lookup_req) begin
          nxt_state = daft_st_scan;
          nxt_idx = 5'h00;
          nxt_da = lookup_da;
          nxt_port = lookup_port;
        end
      end
      daft_st_scan: begin
        nxt_chk = !idx_ff[4];
        nxt_idx = idx_ff[4] ? idx_ff : idx_ff + 5'h01;
        if (e_match) begin
          nxt_state = daft_st_done;
          nxt_done = 1'b1;
          nxt_hit = 1'b1;
          nxt_hit_upr = e_upr;
          nxt_hit_addr = e_addr;
          nxt_hit_mask = e_mask;
        end else if (chk_ff && chk_idx_ff == `DAFT_LAST_IDX) begin
          nxt_state = daft_st_done;
          nxt_done = 1'b1;
          nxt_hit = 1'b0;
          nxt_hit_upr = 32'h00000000;
        end
      end
      daft_st_done: begin
        nxt_state = daft_st_idle;
      end
      default: begin
        nxt_state = daft_st_idle;
      end
    endcase
    nxt_drop = nxt_hit && !nxt_hit_upr[`DAFT_BIT_HOST] && !nxt_hit_upr[`DAFT_BIT_PEER];
    nxt_hipri = nxt_hit_upr[`DAFT_BIT_HIPRI] && nxt_hit_upr[`DAFT_BIT_HOST];
    nxt_busy = (nxt_state != daft_st_idle);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= daft_st_idle;
      idx_ff <= 5'h00;
      chk_ff <= 1'b0;
      chk_idx_ff <= 4'h0;
      da_ff <= 48'h000000000000;
      port_ff <= daft_rx_first;
      done_ff <= 1'b0;
      hit_ff <= 1'b0;
      busy_ff <= 1'b0;
      hit_upr_ff <= 32'h00000000;
      hit_addr_ff <= 48'h000000000000;
      hit_mask_ff <= 48'h000000000000;
      drop_ff <= 1'b0;
      hipri_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      chk_ff <= nxt_chk;
      chk_idx_ff <= nxt_chk_idx;
      da_ff <= nxt_da;
      port_ff <= nxt_port;
      done_ff <= nxt_done;
      hit_ff <= nxt_hit;
      busy_ff <= nxt_busy;
      hit_upr_ff <= nxt_hit_upr;
      hit_addr_ff <= nxt_hit_addr;
      hit_mask_ff <= nxt_hit_mask;
      drop_ff <= nxt_drop;
      hipri_ff <= nxt_hipri;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign lookup_busy = busy_ff;
  assign lookup_done = done_ff;
  assign lookup_hit = hit_ff;
  assign forward_port_a = hit_upr_ff[`DAFT_BIT_HOST];
  assign forward_to_peer_port = hit_upr_ff[`DAFT_BIT_PEER];
  assign host_queue_priority = hipri_ff;
  assign lookup_drop = drop_ff;
  sequence s_accept;
    state_ff == daft_st_idle && lookup_req;
  endsequence
  sequence s_answer;
    ##[`DAFT_ANS_MIN:`DAFT_ANS_MAX] lookup_done;
  endsequence
  property p_answer_bound;
    @(posedge clock) disable iff (!resetn) s_accept |-> s_answer;
  endproperty
  a_answer_bound: assert property (p_answer_bound) else $error("lookup answer late");
  property p_mask_reset;
    @(posedge clock) $past(!resetn) && resetn |-> mask_ff[0] == `DAFT_MASK_FULL && mask_ff[1] == `DAFT_MASK_FULL;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not ones after reset");
  property p_upr_reserved;
    @(posedge clock) disable iff (!resetn)
      rvalid_ff && $past(rd_dec_ff.filt) && !$past(rd_dec_ff.lower) |-> (rdata_ff & ~`DAFT_UPR_WMASK) == 32'h00000000;
  endproperty
  a_upr_reserved: assert property (p_upr_reserved) else $error("reserved upper bits set");
  property p_hit_match;
    @(posedge clock) disable iff (!resetn) done_ff && hit_ff |-> ((hit_addr_ff ^ da_ff) & hit_mask_ff) == 48'h000000000000;
  endproperty
  a_hit_match: assert property (p_hit_match) else $error("hit on mismatching address");
  property p_port_enable;
    @(posedge clock) disable iff (!resetn)
      done_ff && hit_ff |-> hit_upr_ff[port_ff == daft_rx_second ? `DAFT_BIT_PORT2 : `DAFT_BIT_PORT1];
  endproperty
  a_port_enable: assert property (p_port_enable) else $error("hit on entry not enabled for port");
  property p_drop;
    @(posedge clock) disable iff (!resetn) done_ff && hit_ff && !forward_port_a && !forward_to_peer_port |-> lookup_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("unforwarded hit not dropped");
  property p_busy_done;
    @(posedge clock) disable iff (!resetn) lookup_done |-> lookup_busy ##1 !lookup_busy;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy not ending after answer");
endmodule

/* File: bench/daft_host_model.sv */
// Host model: programs and reads the table over the register port.
// Assumes the bench calls its tasks; signals change 1 ns after the rising edge.
`timescale 1ns/1ps
module daft_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
  end

  // Write pulse, then bus shows inverted leftovers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read pulse, answer awaited a bounded time
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 32'h00000000;
    @(posedge clock);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(posedge clock);
        #1;
      end
    end
  endtask

  task automatic put(input logic [7:0] up, input logic [31:0] hi, input logic [31:0] lo);
    wr(up, hi);
    wr(up + 8'h01, lo);
  endtask
endmodule

/* File: bench/dest_address_forward_table_bench.sv */
// Bench: random table contents, lookups checked against computed forwarding.
// Assumes the host model drives the register port; bench drives lookups.
`timescale 1ns/1ps
module dest_address_forward_table_bench;
  import daft_pkg::*;
  logic clock, resetn, reg_wr_en, reg_rd_en, reg_rvalid, lookup_req;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [47:0] lookup_da;
  daft_rx_port_t lookup_port;
  logic lookup_busy, lookup_done, lookup_hit, forward_port_a, forward_to_peer_port, lookup_drop, host_queue_priority;
  int failures, samples_checked;
  logic [31:0] up [16];
  logic [31:0] lo [16];

  daft_top i_daft_top (.clock(clock), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lookup_req(lookup_req), .lookup_da(lookup_da), .lookup_port(lookup_port), .lookup_busy(lookup_busy),
    .lookup_done(lookup_done), .lookup_hit(lookup_hit), .forward_port_a(forward_port_a),
    .forward_to_peer_port(forward_to_peer_port), .lookup_drop(lookup_drop),
    .host_queue_priority(host_queue_priority));
  daft_host_model i_daft_host_model (.clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  always #50 clock = ~clock;

  task automatic complete_run();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      failures++;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic ok;
    i_daft_host_model.rd(a, d, ok);
    if (!ok) begin
      failures++;
      complete_run();
    end
    chk("register", {a, e}, {a, d});
  endtask

  // Hit flag, host, peer, drop, priority
  function automatic logic [4:0] fields(logic [31:0] u, daft_rx_port_t p);
    if (((p == daft_rx_second) ? u[31] : u[30]) !== 1'b1) begin
      return 5'h00;
    end
    return {1'b1, u[16], u[17], ~u[16] & ~u[17], u[19] & u[16]};
  endfunction

  task automatic look(input logic [47:0] da, input daft_rx_port_t p, input int lat, input logic [4:0] e);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    lookup_req = 1'b1;
    lookup_da = da;
    lookup_port = p;
    @(posedge clock);
    #1;
    lookup_req = 1'b0;
    lookup_da = ~da;
    chk("busy", 64'h1, 64'(lookup_busy));
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (lookup_done !== 1'b1 && n < 30);
    if (lookup_done !== 1'b1) begin
      failures++;
      complete_run();
    end
    // The edge that samples the request is counted as well
    chk("latency", 64'(lat), 64'(n + 1));
    chk("result", {59'h0, e}, {59'h0, lookup_hit, forward_port_a, forward_to_peer_port, lookup_drop,
      host_queue_priority});
  endtask

  initial begin
    daft_rx_port_t p;
    clock = 1'b0;
    resetn = 1'b0;
    lookup_req = 1'b0;
    lookup_da = 48'h000000000000;
    lookup_port = daft_rx_first;
    failures = 0;
    samples_checked = 0;
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'b1;
    void'($urandom(40144));
    for (int k = 0; k < 16; k++) rchk(8'h50 + 8'(2 * k), 32'h00000000);
    rchk(8'h70, 32'h0000FFFF);
    rchk(8'h71, 32'hFFFFFFFF);
    rchk(8'h73, 32'hFFFFFFFF);
    rchk(8'h40, 32'h00000000);
    i_daft_host_model.wr(8'h56, 32'hFFFFFFFF);
    rchk(8'h56, 32'h00000000);
    i_daft_host_model.wr(8'h57, 32'h12345678);
    rchk(8'h56, 32'hC00BFFFF);
    rchk(8'h57, 32'h12345678);
    // Queue sizes never moved, so priority is drawn freely
    for (int k = 0; k < 16; k++) begin
      up[k] = $urandom & 32'hC00BFFFF;
      lo[k] = {4'(k), 28'($urandom)};
      i_daft_host_model.put(8'h50 + 8'(2 * k), up[k], lo[k]);
    end
    for (int k = 0; k < 16; k++) begin
      p = daft_rx_port_t'($urandom & 1);
      look({up[k][15:0], lo[k]}, p, (fields(up[k], p) != 5'h00) ? k + 3 : 18, fields(up[k], p));
    end
    for (int c = 0; c < 4; c++) begin
      up[2] = {16'hC008 | 16'(c), up[2][15:0]};
      i_daft_host_model.put(8'h54, up[2], lo[2]);
      look({up[2][15:0], lo[2]}, daft_rx_first, 5, fields(up[2], daft_rx_first));
    end
    look({~up[0][15:0], lo[0]}, daft_rx_second, 18, 5'h00);
    up[0] = {16'hC001, up[0][15:0]};
    i_daft_host_model.put(8'h50, up[0], lo[0]);
    i_daft_host_model.put(8'h70, 32'hFFFFFFFF, 32'hFFFFFF00);
    rchk(8'h70, 32'h0000FFFF);
    look({up[0][15:0], lo[0] ^ 32'h0000005A}, daft_rx_second, 3, fields(up[0], daft_rx_second));
    complete_run();
  end
endmodule
